// ---- hdl/cond_block_unit.sv ----
// conditional block sequencing and table branch target unit
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - up to four instructions after the prefix form one conditional block.
// - slot one uses base condition; later slots use it or its inverse.
// - breakpoint inside a block executes even when its slot fails.
// - exceptions inside a block save block state with return info.
// - exception return restores block state and resumes slot conditions.
// - the prefix itself leaves condition flags unchanged.
// - table offset is twice the unsigned byte or halfword entry.
// - branch target is offset plus address after table branch.
// - program counter base means table starts after the instruction.
// - halfword table index is shifted left one bit.
// - direct conditional branch inside block gets the longer range.
module cond_block_unit #(
  parameter int AW = cond_block_pkg::ADDR_W
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic i_ce,
  input wire cond_block_pkg::insn_in_s i_insn,
  input wire logic [3:0] i_flags,
  input wire logic i_exc_entry,
  input wire logic i_exc_return,
  input wire cond_block_pkg::blk_state_s i_stacked_state,
  input wire logic i_tb_start,
  input wire logic i_tb_half,
  input wire logic i_tb_base_is_pc,
  input wire logic [AW-1:0] i_insn_addr,
  input wire logic [AW-1:0] i_base_val,
  input wire logic [AW-1:0] i_index_val,
  input wire logic i_mem_ready,
  input wire logic [cond_block_pkg::HW_W-1:0] i_mem_data,
  output logic o_execute,
  output logic o_in_block,
  output logic o_last_slot,
  output logic o_flags_write_en,
  output logic [AW-1:0] o_branch_range,
  output cond_block_pkg::blk_state_s o_saved_state,
  output logic o_mem_req,
  output logic [AW-1:0] o_mem_addr,
  output logic o_mem_half,
  output logic o_tb_valid,
  output logic [AW-1:0] o_tb_target
);

  // ************************************************************
  // condition evaluation
  // ************************************************************
  function automatic logic cond_pass(input logic [3:0] c, input logic [3:0] f);
    logic n;
    logic z;
    logic cy;
    logic v;
    logic r;
    n = f[3];
    z = f[2];
    cy = f[1];
    v = f[0];
    unique case (c[3:1])
      3'h0: r = z;
      3'h1: r = cy;
      3'h2: r = n;
      3'h3: r = v;
      3'h4: r = cy & ~z;
      3'h5: r = (n == v);
      3'h6: r = (n == v) & ~z;
      3'h7: r = 1'b1;
    endcase
    if (c[0] && c != cond_block_pkg::NEVER_COND) begin
      r = ~r;
    end
    return r;
  endfunction

  function automatic logic is_prefix(input logic [15:0] w);
    return ((w & cond_block_pkg::IT_MASK) == cond_block_pkg::IT_MATCH) && (w[3:0] != 4'h0);
  endfunction

  // ************************************************************
  // block state
  // ************************************************************
  cond_block_pkg::blk_state_s state;
  cond_block_pkg::blk_state_s next_state;
  logic active;
  logic [3:0] slot_cond;
  logic is_breakpoint_instruction;

  assign active = (state.mask != 4'h0);
  // slot condition: base low bit is refreshed from the mask on each advance
  assign slot_cond = state.base;
  assign is_breakpoint_instruction = (i_insn.insn & cond_block_pkg::BREAKPOINT_INSTRUCTION_MASK) == cond_block_pkg::BREAKPOINT_INSTRUCTION_MATCH;

  always_comb begin
    next_state = state;
    if (i_exc_return) begin
      next_state = i_stacked_state;
    end else if (i_exc_entry) begin
      next_state = '0;
    end else if (i_insn.valid) begin
      if (active) begin
        if (state.mask[2:0] == 3'h0) begin
          // final slot retires, the block is over
          next_state = '0;
        end else begin
          // top mask bit becomes the then/else bit of the next slot
          {next_state.base[0], next_state.mask} = {state.mask, 1'b0};
        end
      end else if (is_prefix(i_insn.insn)) begin
        // the prefix encodes base and a mask of up to four slots
        next_state.base = i_insn.insn[cond_block_pkg::COND_LSB +: 4];
        next_state.mask = i_insn.insn[3:0];
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      state <= '0;
    end else if (i_ce) begin
      state <= next_state;
    end
  end

  always_comb begin
    o_in_block = active;
    o_last_slot = active && (state.mask[2:0] == 3'h0);
    // breakpoint runs even when the slot condition fails
    o_execute = i_insn.valid && (!active || cond_pass(slot_cond, i_flags) || is_breakpoint_instruction);
    // the prefix never writes flags
    o_flags_write_en = i_insn.valid && !(!active && is_prefix(i_insn.insn));
    o_branch_range = (active && i_insn.is_branch) ? cond_block_pkg::BRANCH_FAR
                                                  : cond_block_pkg::BRANCH_NEAR;
    o_saved_state = state;
  end

  // ************************************************************
  // slot counter for the block length check
  // ************************************************************
  logic [2:0] slots_done;
  logic [2:0] next_slots_done;

  always_comb begin
    next_slots_done = '0;
    if (active && next_state.mask != 4'h0 && !i_exc_return) begin
      next_slots_done = slots_done + (i_insn.valid ? 3'h1 : 3'h0);
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      slots_done <= '0;
    end else if (i_ce) begin
      slots_done <= next_slots_done;
    end
  end

  // ************************************************************
  // table branch
  // ************************************************************
  cond_block_pkg::tb_state_e tb_state;
  cond_block_pkg::tb_state_e next_tb_state;
  logic [AW-1:0] tb_next_pc;
  logic [AW-1:0] next_tb_next_pc;
  logic [AW-1:0] mem_addr;
  logic [AW-1:0] next_mem_addr;
  logic tb_half;
  logic next_tb_half;
  logic [AW-1:0] target;
  logic [AW-1:0] next_target;
  logic [AW-1:0] tb_base;
  logic [AW-1:0] tb_index;
  logic [AW-1:0] entry;

  always_comb begin
    tb_base = i_tb_base_is_pc ? (i_insn_addr + cond_block_pkg::INSN_BYTES) : i_base_val;
    tb_index = i_tb_half ? (i_index_val << cond_block_pkg::IDX_HALF_SHIFT) : i_index_val;
    entry = tb_half ? AW'(i_mem_data) : AW'(i_mem_data[7:0]);
    next_tb_state = tb_state;
    next_tb_next_pc = tb_next_pc;
    next_mem_addr = mem_addr;
    next_tb_half = tb_half;
    next_target = target;
    unique case (tb_state)
      cond_block_pkg::TB_IDLE: begin
        if (i_tb_start) begin
          next_tb_state = cond_block_pkg::TB_FETCH;
          next_tb_next_pc = i_insn_addr + cond_block_pkg::INSN_BYTES;
          next_mem_addr = tb_base + tb_index;
          next_tb_half = i_tb_half;
        end
      end
      cond_block_pkg::TB_FETCH: begin
        if (i_mem_ready) begin
          // forward branch by twice the unsigned entry
          next_target = tb_next_pc + (entry << cond_block_pkg::OFS_SHIFT);
          next_tb_state = cond_block_pkg::TB_DONE;
        end
      end
      cond_block_pkg::TB_DONE: begin
        next_tb_state = cond_block_pkg::TB_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      tb_state <= cond_block_pkg::TB_IDLE;
      tb_next_pc <= '0;
      mem_addr <= '0;
      tb_half <= 1'b0;
      target <= '0;
    end else if (i_ce) begin
      tb_state <= next_tb_state;
      tb_next_pc <= next_tb_next_pc;
      mem_addr <= next_mem_addr;
      tb_half <= next_tb_half;
      target <= next_target;
    end
  end

  assign o_mem_req = (tb_state == cond_block_pkg::TB_FETCH);
  assign o_mem_addr = mem_addr;
  assign o_mem_half = tb_half;
  assign o_tb_valid = (tb_state == cond_block_pkg::TB_DONE);
  assign o_tb_target = target;

  // ************************************************************
  // checks
  // ************************************************************
  prefix_loads_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (i_ce && i_insn.valid && !active && is_prefix(i_insn.insn) && !i_exc_entry && !i_exc_return)
      |=> (state.mask == $past(i_insn.insn[3:0])))
    else $error("prefix did not load block state");
  breakpoint_instruction_runs_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (i_insn.valid && is_breakpoint_instruction) |-> o_execute)
    else $error("breakpoint suppressed");
  slot_first_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (i_ce && i_insn.valid && !active && is_prefix(i_insn.insn) && !i_exc_entry && !i_exc_return)
      ##1 (i_insn.valid && !is_breakpoint_instruction && !i_exc_return)
      |-> (o_execute == cond_pass($past(i_insn.insn[7:4]), i_flags)))
    else $error("first slot condition wrong");
  exc_save_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (i_ce && i_exc_entry && !i_exc_return) |=> (state == '0 && $past(o_saved_state) == $past(state)))
    else $error("exception entry did not clear block");
  exc_resume_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (i_ce && i_exc_return) |=> (state == $past(i_stacked_state)))
    else $error("exception return lost block state");
  prefix_flags_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (i_insn.valid && !active && is_prefix(i_insn.insn)) |-> !o_flags_write_en)
    else $error("prefix wrote flags");
  tb_target_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (i_ce && tb_state == cond_block_pkg::TB_FETCH && i_mem_ready)
      |=> (o_tb_valid && o_tb_target == $past(tb_next_pc) + ($past(entry) << 1)))
    else $error("table target wrong");
  tb_pc_base_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (i_ce && tb_state == cond_block_pkg::TB_IDLE && i_tb_start && i_tb_base_is_pc && !i_tb_half)
      |=> (o_mem_addr == $past(i_insn_addr) + 32'h4 + $past(i_index_val)))
    else $error("pc based table address wrong");
  tb_half_idx_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (i_ce && tb_state == cond_block_pkg::TB_IDLE && i_tb_start && !i_tb_base_is_pc && i_tb_half)
      |=> (o_mem_addr == $past(i_base_val) + ($past(i_index_val) << 1)))
    else $error("halfword index not doubled");
  range_long_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (active && i_insn.is_branch) |-> (o_branch_range > cond_block_pkg::BRANCH_NEAR))
    else $error("in block branch range short");
  block_ends_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (i_ce && active && state.mask == 4'h8 && i_insn.valid && !i_exc_entry && !i_exc_return)
      |=> !active)
    else $error("block state not cleared after last slot");
  slots_bound_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    active |-> (int'(slots_done) < cond_block_pkg::SLOT_W))
    else $error("block longer than four slots");
  true_block_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (active && i_insn.valid && state.base[3:1] == cond_block_pkg::TRUE_COND[3:1])
      |-> o_execute)
    else $error("true condition slot suppressed");
  outside_runs_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (!active && i_insn.valid) |-> o_execute)
    else $error("instruction outside block suppressed");
  slot_flags_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (active && i_insn.valid) |-> o_flags_write_en)
    else $error("block slot lost flag write");
  exc_block_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (i_ce && i_exc_entry && !i_exc_return) |=> !o_in_block)
    else $error("block active after exception entry");
  last_inside_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    o_last_slot |-> o_in_block)
    else $error("last slot flagged outside block");
  ce_freeze_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    !i_ce |=> ($stable(state) && $stable(tb_state)))
    else $error("state moved while clock enable low");
  range_short_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    !active |-> (o_branch_range == cond_block_pkg::BRANCH_NEAR))
    else $error("branch range long outside block");
  tb_hold_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (i_ce && tb_state == cond_block_pkg::TB_FETCH && !i_mem_ready)
      |=> (o_mem_req && $stable(o_mem_addr)))
    else $error("table fetch dropped before entry");
  tb_pulse_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (i_ce && o_tb_valid) |=> !o_tb_valid)
    else $error("table target valid too long");

endmodule

`default_nettype wire

// ---- hdl/cond_block_pkg.sv ----
// package for the conditional block and table branch unit
package cond_block_pkg;
  localparam int ADDR_W = 32;
  localparam int HW_W = 16;
  localparam int INSN_W = 16;
  localparam logic [3:0] TRUE_COND = 4'he;
  localparam logic [3:0] NEVER_COND = 4'hf;
  localparam logic [15:0] IT_MASK = 16'hff00;
  localparam logic [15:0] IT_MATCH = 16'hbf00;
  localparam logic [15:0] BREAKPOINT_INSTRUCTION_MASK = 16'hff00;
  localparam logic [15:0] BREAKPOINT_INSTRUCTION_MATCH = 16'hbe00;
  localparam int COND_LSB = 4;
  localparam int SLOT_W = 4;
  localparam logic [ADDR_W-1:0] INSN_BYTES = 32'h0000_0004;
  localparam logic [ADDR_W-1:0] IDX_HALF_SHIFT = 32'h0000_0001;
  localparam logic [ADDR_W-1:0] OFS_SHIFT = 32'h0000_0001;
  localparam logic [ADDR_W-1:0] BRANCH_NEAR = 32'h0010_0000;
  localparam logic [ADDR_W-1:0] BRANCH_FAR = 32'h0100_0000;

  // block state carried in the stacked status word
  typedef struct packed {
    logic [3:0] base;
    logic [3:0] mask;
  } blk_state_s;

  typedef struct packed {
    logic valid;
    logic [INSN_W-1:0] insn;
    logic is_branch;
  } insn_in_s;

  typedef enum logic [1:0] {
    TB_IDLE,
    TB_FETCH,
    TB_DONE
  } tb_state_e;
endpackage

// ---- tb/tbl_mem.sv ----
// memory partner that answers table entry fetches
`timescale 1ns/1ps
`default_nettype none
module tbl_mem (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic [31:0] i_addr,
  input wire logic [3:0] i_lat,
  output logic o_ready,
  output logic [15:0] o_data
);
  logic [3:0] cnt;
  // data toggles whenever no entry is offered
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ready <= 1'b0;
      cnt <= 4'h0;
      o_data <= 16'ha5a5;
    end else if (o_ready) begin
      o_ready <= 1'b0;
      o_data <= ~o_data;
    end else if (i_req && cnt == i_lat) begin
      o_ready <= 1'b1;
      cnt <= 4'h0;
      o_data <= i_addr[15:0] ^ 16'h3c5a;
    end else begin
      cnt <= cnt + (i_req ? 4'h1 : 4'h0);
      o_data <= ~o_data;
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb_cond_block_unit.sv ----
// testbench for the conditional block and table branch unit
`timescale 1ns/1ps
`default_nettype none
module tb_cond_block_unit;
  logic clk, rst, ce, exc_e, exc_r, tbs, halfword_table_branch, tbpc, exe, inb, last, fwe;
  logic mreq, mhalf, mrdy, tbv;
  logic [3:0] flags, lat;
  logic [31:0] iaddr, base, idx, rng, maddr, tgt;
  logic [15:0] mdata;
  cond_block_pkg::insn_in_s insn;
  cond_block_pkg::blk_state_s stk, sav;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  cond_block_unit cond_block_unit_inst (.I_SYS_CLK(clk), .I_RST(rst), .i_ce(ce),
    .i_insn(insn), .i_flags(flags), .i_exc_entry(exc_e), .i_exc_return(exc_r),
    .i_stacked_state(stk), .i_tb_start(tbs), .i_tb_half(halfword_table_branch), .i_tb_base_is_pc(tbpc),
    .i_insn_addr(iaddr), .i_base_val(base), .i_index_val(idx), .i_mem_ready(mrdy),
    .i_mem_data(mdata), .o_execute(exe), .o_in_block(inb), .o_last_slot(last),
    .o_flags_write_en(fwe), .o_branch_range(rng), .o_saved_state(sav),
    .o_mem_req(mreq), .o_mem_addr(maddr), .o_mem_half(mhalf), .o_tb_valid(tbv),
    .o_tb_target(tgt));
  tbl_mem tbl_mem_inst (.i_clk(clk), .i_rst(rst), .i_req(mreq), .i_addr(maddr),
    .i_lat(lat), .o_ready(mrdy), .o_data(mdata));
  always #12.5 clk = ~clk;
  task automatic final_report;
    $display("checks %0d errors %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      final_report;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic put(input logic v, input logic [15:0] w, input logic br);
    @(negedge clk);
    insn = '{v, w, br};
    #1;
  endtask
  // prefix p, then n slots with flags f, expected execute bits e
  task automatic blk(input logic [15:0] p, input logic [3:0] f, input logic [3:0] e,
                     input int n);
    put(1'b1, p, 1'b0);
    flags = f;
    #1;
    chk("fwe", 32'h0, {31'h0, fwe});
    for (int i = 0; i < n; i++) begin
      put(1'b1, 16'h1c08, 1'b0);
      chk("inb", 32'h1, {31'h0, inb});
      chk("exe", {31'h0, e[3-i]}, {31'h0, exe});
      chk("last", {31'h0, i == n - 1}, {31'h0, last});
      chk("fwe", 32'h1, {31'h0, fwe});
    end
    put(1'b0, 16'h0, 1'b0);
    chk("inb", 32'h0, {31'h0, inb});
  endtask
  task automatic brk_in_block;
    put(1'b1, 16'hbf18, 1'b0);
    flags = 4'h4;
    put(1'b1, 16'hbe01, 1'b0);
    chk("exe", 32'h1, {31'h0, exe});
    put(1'b0, 16'h0, 1'b0);
  endtask
  // four-slot block interrupted after slot one, then resumed
  task automatic exc_resume;
    cond_block_pkg::blk_state_s s;
    put(1'b1, 16'hbf07, 1'b0);
    flags = 4'h4;
    put(1'b1, 16'h1c08, 1'b0);
    chk("exe", 32'h1, {31'h0, exe});
    ce = 1'b0;
    put(1'b1, 16'h1c08, 1'b0);
    ce = 1'b1;
    put(1'b0, 16'h0, 1'b0);
    exc_e = 1'b1;
    s = sav;
    chk("sav", 32'h0000_000e, {24'h0, s});
    put(1'b0, 16'h0, 1'b0);
    exc_e = 1'b0;
    chk("inb", 32'h0, {31'h0, inb});
    repeat (3) put(1'b0, 16'h0, 1'b0);
    exc_r = 1'b1;
    stk = s;
    put(1'b0, 16'h0, 1'b0);
    exc_r = 1'b0;
    for (int i = 0; i < 3; i++) begin
      put(1'b1, 16'h1c08, 1'b0);
      chk("exe", {31'h0, i == 0}, {31'h0, exe});
      chk("last", {31'h0, i == 2}, {31'h0, last});
    end
    put(1'b0, 16'h0, 1'b0);
    chk("inb", 32'h0, {31'h0, inb});
  endtask
  task automatic branch_range;
    put(1'b1, 16'hd000, 1'b1);
    chk("rng", 32'h0010_0000, rng);
    put(1'b1, 16'hbf08, 1'b0);
    put(1'b1, 16'hd000, 1'b1);
    chk("rng", 32'h0100_0000, rng);
    put(1'b0, 16'h0, 1'b0);
  endtask
  task automatic tbl(input logic h, input logic pc, input logic [3:0] l);
    logic [31:0] a, o;
    logic [15:0] w;
    @(negedge clk);
    lat = l;
    halfword_table_branch = h;
    tbpc = pc;
    iaddr = 32'h0000_1000;
    base = 32'h0000_2200;
    idx = 32'h0000_0013;
    tbs = 1'b1;
    a = (pc ? iaddr + 32'h4 : base) + (h ? idx << 1 : idx);
    w = a[15:0] ^ 16'h3c5a;
    o = h ? {15'h0, w, 1'b0} : {23'h0, w[7:0], 1'b0};
    @(negedge clk);
    tbs = 1'b0;
    chk("mreq", 32'h1, {31'h0, mreq});
    chk("maddr", a, maddr);
    chk("mhalf", {31'h0, h}, {31'h0, mhalf});
    for (int k = 0; k < 20 && tbv !== 1'b1; k++) @(negedge clk);
    chk("tbv", 32'h1, {31'h0, tbv});
    chk("tgt", iaddr + 32'h4 + o, tgt);
    @(negedge clk);
    chk("tbv", 32'h0, {31'h0, tbv});
  endtask
  initial begin
    clk = 0; rst = 1; ce = 1; insn = '0; flags = 0; exc_e = 0; exc_r = 0;
    stk = '0; tbs = 0; halfword_table_branch = 0; tbpc = 0; iaddr = 0; base = 0; idx = 0; lat = 0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst = 0;
    chk("rng", 32'h0010_0000, rng);
    chk("inb", 32'h0, {31'h0, inb});
    blk(16'hbf08, 4'h0, 4'b0000, 1);
    blk(16'hbf07, 4'h4, 4'b1100, 4);
    blk(16'hbf07, 4'h0, 4'b0011, 4);
    blk(16'hbfe1, 4'h0, 4'b1111, 4);
    brk_in_block;
    exc_resume;
    branch_range;
    tbl(1'b0, 1'b0, 4'h0);
    tbl(1'b1, 1'b0, 4'h3);
    tbl(1'b0, 1'b1, 4'h2);
    tbl(1'b1, 1'b1, 4'h0);
    final_report;
  end
endmodule
`default_nettype wire
